// ==== inc/mrx_pkg.sv ====
// mrx_pkg: constants, enums and carriers for the mii receive block
// assumes core_clk at 100 mhz stands for the local reference domain
package mrx_pkg;

  // ********************************************************
  // clock rates and derived periods
  // ********************************************************
  localparam int unsigned CORE_HZ = 100_000_000;
  localparam int unsigned RXCLK_HZ_100 = 25_000_000;
  localparam int unsigned RXCLK_HZ_10 = 2_500_000;
  localparam int PH_W = 6;
  localparam logic [PH_W-1:0] PER_100 = PH_W'(CORE_HZ / RXCLK_HZ_100);
  localparam logic [PH_W-1:0] PER_10 = PH_W'(CORE_HZ / RXCLK_HZ_10);
  localparam logic [PH_W-1:0] PH_STEP = PH_W'(1);
  localparam int GAP_W = 7;

  // ********************************************************
  // synchroniser bit positions and reset pattern
  // ********************************************************
  localparam int SY_N = 5;
  localparam int SY_TRI = 0;
  localparam int SY_LINK = 1;
  localparam int SY_SPD = 2;
  localparam int SY_CARR = 3;
  localparam int SY_TGL = 4;
  // tri request resets high so the pins start released
  localparam logic [SY_N-1:0] SY_RST = 5'h01;

  // ********************************************************
  // line symbols, events and states
  // ********************************************************
  typedef enum logic [2:0] {
    SYM_IDLE = 3'h0,
    SYM_DATA = 3'h1,
    SYM_SSD1 = 3'h2,
    SYM_SSD2 = 3'h3,
    SYM_ESD1 = 3'h4,
    SYM_ESD2 = 3'h5,
    SYM_BAD = 3'h6
  } mrx_sym_kind_t;

  typedef struct packed {
    mrx_sym_kind_t kind;
    logic [3:0] nibble;
  } mrx_sym_t;

  typedef enum logic [1:0] {
    EVT_NIB = 2'h0,
    EVT_START = 2'h1,
    EVT_END = 2'h2,
    EVT_ABORT = 2'h3
  } mrx_evt_t;

  typedef struct packed {
    mrx_evt_t evt;
    logic [3:0] nibble;
  } mrx_xfer_t;

  typedef struct packed {
    logic clk;
    logic dv;
    logic er;
    logic [3:0] data;
  } mrx_mii_t;

  typedef enum logic [3:0] {
    LN_HUNT = 4'h1,
    LN_SSD = 4'h2,
    LN_STREAM = 4'h4,
    LN_ESD = 4'h8
  } mrx_ln_state_t;

endpackage

// ==== verilog/mrx_line_intake.sv ====
// mrx_line_intake: delimiter tracking on the recovered line clock
// assumes one decoded symbol per lineClk edge; lineClk may stop when idle
`timescale 1ns/10ps
`default_nettype none
module mrx_line_intake
(
  input wire logic lineClk,
  input wire logic resetn,
  input wire mrx_pkg::mrx_sym_t lineSym,
  output var mrx_pkg::mrx_xfer_t xferWord,
  output logic xferTgl,
  output logic carrier
);
  import mrx_pkg::*;

  // ********************************************************
  // reset brought into the line domain
  // ********************************************************
  logic rstS1Q;
  logic rstS2Q;

  always_ff @(posedge lineClk)
  begin
    rstS1Q <= resetn;
    rstS2Q <= rstS1Q;
  end

  // ********************************************************
  // stream delimiter tracking
  // ********************************************************
  mrx_ln_state_t stateQ;
  mrx_ln_state_t stateD;
  mrx_xfer_t wordQ;
  mrx_xfer_t wordD;
  logic tglQ;
  logic tglD;
  logic carrQ;
  logic carrD;
  logic post;
  mrx_evt_t postEvt;

  always_comb
  begin
    stateD = stateQ;
    post = 1'b0;
    postEvt = EVT_NIB;
    unique case (stateQ)
      LN_HUNT:
      begin
        if (lineSym.kind == SYM_SSD1)
          stateD = LN_SSD;
      end
      LN_SSD:
      begin
        // start only once both delimiter halves are
        if (lineSym.kind == SYM_SSD2)
        begin
          stateD = LN_STREAM;
          post = 1'b1;
          postEvt = EVT_START;
        end
        else
          stateD = LN_HUNT;
      end
      LN_STREAM:
      begin
        if (lineSym.kind == SYM_DATA)
          post = 1'b1;
        else if (lineSym.kind == SYM_ESD1)
          stateD = LN_ESD;
        else
        begin
          stateD = LN_HUNT;
          post = 1'b1;
          postEvt = EVT_ABORT;
        end
      end
      LN_ESD:
      begin
        stateD = LN_HUNT;
        post = 1'b1;
        // end pair closes the frame, anything else is a signal error
        postEvt = (lineSym.kind == SYM_ESD2) ? EVT_END : EVT_ABORT;
      end
      default:
        stateD = LN_HUNT;
    endcase
    wordD = post ? mrx_xfer_t'{evt: postEvt, nibble: lineSym.nibble} : wordQ;
    // word and toggle move together; word then holds a full line period
    tglD = post ? ~tglQ : tglQ;
    carrD = (lineSym.kind != SYM_IDLE);
  end

  always_ff @(posedge lineClk)
  begin
    if (!rstS2Q)
    begin
      stateQ <= LN_HUNT;
      wordQ <= '0;
      tglQ <= 1'b0;
      carrQ <= 1'b0;
    end
    else
    begin
      stateQ <= stateD;
      wordQ <= wordD;
      tglQ <= tglD;
      carrQ <= carrD;
    end
  end

  assign xferWord = wordQ;
  assign xferTgl = tglQ;
  assign carrier = carrQ;

endmodule
`default_nettype wire

// ==== verilog/mrx_receive.sv ====
// mrx_receive: mii receive clock, data and valid toward the mac
// assumes lineClk period of at least six core_clk cycles
//
// Operation
// - 10 Mb/s mode drives the receive clock at 2.5 MHz.
// - 100 Mb/s mode drives the receive clock at 25 MHz.
// - 10 Mb/s receive clock is recovered from the line by a DPLL.
// - 10 Mb/s loop keeps running on the last packet's timing.
// - 100 Mb/s clock follows the line while a valid link exists.
// - 100 Mb/s clock comes from the local reference without link.
// - 10 Mb/s source switch after carrier sense, before data valid.
// - 10 Mb/s lock may shift clock phase up to 360 degrees.
// - 100 Mb/s link bring-up may shift clock phase 360 degrees.
// - 10 Mb/s clock realigns once per received packet.
// - 100 Mb/s clock aligns once at link establishment only.
// - receive clock output is gated by the mac tri-state request.
// - receive clock times data, data valid and error outputs.
// - nibble on four lines, line zero least significant.
// - nibble updates on receive clock rising edges while valid.
// - 100 Mb/s data valid rises only after start delimiter pair.
// - data valid falls after end delimiter pair or signal error.
// - data valid changes only in step with the receive clock.
`timescale 1ns/10ps
`default_nettype none
module mrx_receive
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic lineClk,
  input wire mrx_pkg::mrx_sym_t lineSym,
  input wire logic linkUp,
  input wire logic speed100,
  input wire logic rxTriReq,
  output var mrx_pkg::mrx_mii_t mii,
  output logic miiOe,
  output logic carrierSense
);
  import mrx_pkg::*;

  // ********************************************************
  // line domain intake
  // ********************************************************
  mrx_xfer_t lineWord;
  logic lineTgl;
  logic lineCarr;

  mrx_line_intake u_line
  (
    .lineClk(lineClk),
    .resetn(resetn),
    .lineSym(lineSym),
    .xferWord(lineWord),
    .xferTgl(lineTgl),
    .carrier(lineCarr)
  );

  // ********************************************************
  // pin and cross-domain synchronisers
  // ********************************************************
  logic [SY_N-1:0] pinIn;
  logic [SY_N-1:0] s1Q;
  logic [SY_N-1:0] s2Q;
  logic [SY_N-1:0] s3Q;
  logic [SY_N-1:0] fltQ;
  logic [SY_N-1:0] fltD;

  assign pinIn[SY_TRI] = rxTriReq;
  assign pinIn[SY_LINK] = linkUp;
  assign pinIn[SY_SPD] = speed100;
  assign pinIn[SY_CARR] = lineCarr;
  assign pinIn[SY_TGL] = lineTgl;

  // a change is taken only once stages two and three agree
  always_comb
  begin
    fltD = (s3Q & ~(s2Q ^ s3Q)) | (fltQ & (s2Q ^ s3Q));
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s1Q <= SY_RST;
      s2Q <= SY_RST;
      s3Q <= SY_RST;
      fltQ <= SY_RST;
    end
    else
    begin
      s1Q <= pinIn;
      s2Q <= s1Q;
      s3Q <= s2Q;
      fltQ <= fltD;
    end
  end

  logic triF;
  logic linkF;
  logic spdF;
  logic carrF;
  logic xferEvt;

  assign triF = fltQ[SY_TRI];
  assign linkF = fltQ[SY_LINK];
  assign spdF = fltQ[SY_SPD];
  assign carrF = fltQ[SY_CARR];
  // word is still held by the line side when the toggle lands here
  assign xferEvt = fltD[SY_TGL] ^ fltQ[SY_TGL];

  // ********************************************************
  // clock generation and frame presentation
  // ********************************************************
  logic [PH_W-1:0] phaseQ;
  logic [PH_W-1:0] phaseD;
  logic [PH_W-1:0] perD;
  logic [PH_W-1:0] halfD;
  logic alignPendQ;
  logic alignPendD;
  logic srcLineQ;
  logic srcLineD;
  logic linkSeenQ;
  logic carrSeenQ;
  logic streamQ;
  logic streamD;
  logic [3:0] holdQ;
  logic [3:0] holdD;
  logic holdValidQ;
  logic holdValidD;
  logic endPendQ;
  logic endPendD;
  logic abortPendQ;
  logic abortPendD;
  mrx_mii_t miiQ;
  mrx_mii_t miiD;
  logic alignEvt;
  logic riseNow;

  always_comb
  begin
    perD = spdF ? PER_100 : PER_10;
    halfD = perD >> 1;
    srcLineD = srcLineQ;
    alignPendD = alignPendQ;
    // phase snaps to the first line event after an align request;
    // the jump may cost up to a full clock period
    alignEvt = alignPendQ && xferEvt;
    if (alignEvt)
      alignPendD = 1'b0;
    if (spdF)
    begin
      // line timing with link, local free-run without
      srcLineD = linkF;
      // one alignment per link bring-up, none per packet
      if (linkF && !linkSeenQ)
        alignPendD = 1'b1;
      if (!linkF)
        alignPendD = 1'b0;
    end
    else if (carrF && !carrSeenQ)
    begin
      // source moves to the line on carrier, ahead of valid
      srcLineD = 1'b1;
      // realign once per packet
      alignPendD = 1'b1;
    end
    // otherwise the loop free-runs on last packet's phase
    if (alignEvt || phaseQ >= perD - PH_STEP)
      phaseD = '0;
    else
      phaseD = phaseQ + PH_STEP;
    // an align landing with the clock high waits for a real rise
    riseNow = (phaseD == '0) && !miiQ.clk;

    miiD = miiQ;
    miiD.clk = (phaseD < halfD);
    streamD = streamQ;
    holdD = holdQ;
    holdValidD = holdValidQ;
    endPendD = endPendQ;
    abortPendD = abortPendQ;
    // outputs move only on the edge where the clock rises
    if (riseNow)
    begin
      if (abortPendQ)
      begin
        // error ends the frame at the very next edge
        miiD.dv = 1'b0;
        miiD.er = spdF && miiQ.dv;
        streamD = 1'b0;
        holdValidD = 1'b0;
        endPendD = 1'b0;
        abortPendD = 1'b0;
      end
      else if (holdValidQ && streamQ && !alignPendQ)
      begin
        miiD.data = holdQ;
        miiD.dv = 1'b1;
        miiD.er = 1'b0;
        holdValidD = 1'b0;
      end
      else
      begin
        // gap or end delimiter: valid drops on this edge
        miiD.dv = 1'b0;
        miiD.er = 1'b0;
        if (endPendQ)
        begin
          streamD = 1'b0;
          endPendD = 1'b0;
        end
      end
    end
    // arriving events are applied last so they win over clears
    if (xferEvt)
    begin
      unique case (lineWord.evt)
        EVT_START:
        begin
          streamD = 1'b1;
          holdValidD = 1'b0;
          endPendD = 1'b0;
          abortPendD = 1'b0;
        end
        EVT_NIB:
        begin
          if (streamQ)
          begin
            holdD = lineWord.nibble;
            holdValidD = 1'b1;
          end
        end
        EVT_END:
          endPendD = streamQ;
        EVT_ABORT:
          abortPendD = streamQ;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      phaseQ <= '0;
      alignPendQ <= 1'b0;
      srcLineQ <= 1'b0;
      linkSeenQ <= 1'b0;
      carrSeenQ <= 1'b0;
      streamQ <= 1'b0;
      holdQ <= '0;
      holdValidQ <= 1'b0;
      endPendQ <= 1'b0;
      abortPendQ <= 1'b0;
      miiQ <= '0;
    end
    else
    begin
      phaseQ <= phaseD;
      alignPendQ <= alignPendD;
      srcLineQ <= srcLineD;
      linkSeenQ <= linkF;
      carrSeenQ <= carrF;
      streamQ <= streamD;
      holdQ <= holdD;
      holdValidQ <= holdValidD;
      endPendQ <= endPendD;
      abortPendQ <= abortPendD;
      miiQ <= miiD;
    end
  end

  // ********************************************************
  // pin outputs
  // ********************************************************
  assign mii = miiQ;
  // all receive pins released together on request
  assign miiOe = ~triF;
  assign carrierSense = carrF;

  // ********************************************************
  // checks
  // ********************************************************
  logic [GAP_W-1:0] gapQ;
  logic skipQ;
  logic spdPrevQ;

  // cycles between rises; periods disturbed by align or speed skipped
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      gapQ <= GAP_W'(1);
      skipQ <= 1'b1;
      spdPrevQ <= 1'b0;
    end
    else
    begin
      gapQ <= riseNow ? GAP_W'(1) : gapQ + GAP_W'(1);
      skipQ <= riseNow ? alignEvt : (skipQ || alignEvt || (spdF ^ spdPrevQ));
      spdPrevQ <= spdF;
    end
  end

  a_rate_fast: assert property (@(posedge core_clk) disable iff (!resetn)
    riseNow && spdF && spdPrevQ && !skipQ && !alignEvt
    |-> gapQ == GAP_W'(PER_100))
    else $error("receive clock period wrong in fast mode");

  a_rate_slow: assert property (@(posedge core_clk) disable iff (!resetn)
    riseNow && !spdF && !spdPrevQ && !skipQ && !alignEvt
    |-> gapQ == GAP_W'(PER_10))
    else $error("receive clock period wrong in slow mode");

  a_valid_on_edge: assert property (@(posedge core_clk) disable iff (!resetn)
    $changed(miiQ.dv) |-> $rose(miiQ.clk))
    else $error("data valid moved away from a clock rise");

  a_data_on_edge: assert property (@(posedge core_clk) disable iff (!resetn)
    $changed(miiQ.data) |-> $rose(miiQ.clk) && miiQ.dv)
    else $error("nibble changed outside a valid clock rise");

  a_valid_after_start: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(miiQ.dv) |-> $past(streamQ) && $past(holdValidQ))
    else $error("data valid rose without a start delimiter");

  a_abort_drops: assert property (@(posedge core_clk) disable iff (!resetn)
    riseNow && abortPendQ && !xferEvt |=> !miiQ.dv && !streamQ)
    else $error("data valid held after signal error");

  a_source_fast: assert property (@(posedge core_clk) disable iff (!resetn)
    spdF |=> srcLineQ == $past(linkF))
    else $error("fast clock source does not follow link state");

  a_switch_first: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(miiQ.dv) && !spdF |-> srcLineQ && $past(!alignPendQ))
    else $error("slow source switch not done before data valid");

  a_align_once: assert property (@(posedge core_clk) disable iff (!resetn)
    spdF && linkF && linkSeenQ && !alignPendQ |=> !alignPendQ)
    else $error("fast mode realigned while link held");

  a_tri_release: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(s3Q[SY_TRI]) && s2Q[SY_TRI] |=> !miiOe)
    else $error("pins not released after tri-state request");

endmodule
`default_nettype wire

// ==== verification/mrx_mac_model.sv ====
// mrx_mac_model: mac side of the receive pins, collects nibbles
// assumes pin shows the wire level, released pins already resolved
`timescale 1ns/10ps
`default_nettype none
module mrx_mac_model
(
  input wire mrx_pkg::mrx_mii_t pin,
  input wire logic rxTriReq
);
  import mrx_pkg::*;
  // ********************************************************
  // sampling on receive clock rises
  // ********************************************************
  mrx_mii_t atRise;
  mrx_mii_t atFall;
  logic [3:0] nibbles [$];
  int unstable = 0;
  int errs = 0;
  // no period check: lock may slip phase a whole cycle
  // a rise takes what stood since the fall, not what it launches
  always @(posedge pin.clk)
  begin
    atRise = pin;
    // data lines ignored while valid is low
    if (!rxTriReq && atFall.dv === 1'b1)
      nibbles.push_back(atFall.data);
    if (!rxTriReq && atFall.er === 1'b1)
      errs++;
  end
  // outputs must hold between rises
  always @(negedge pin.clk)
  begin
    if (!rxTriReq && {pin.dv, pin.er, pin.data} !==
      {atRise.dv, atRise.er, atRise.data})
      unstable++;
    atFall = pin;
  end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// testbench: line symbols into mrx_receive, mac model on the pins
// assumes lineClk runs only while symbols are sent
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import mrx_pkg::*;
  // ********************************************************
  // signals, rows and counters
  // ********************************************************
  typedef struct {logic spd; logic link; int perNs;} mrx_row_t;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic lineClk = 1'b0;
  mrx_sym_t lineSym = '{SYM_IDLE, 4'h0};
  logic linkUp = 1'b1;
  logic speed100 = 1'b1;
  logic rxTriReq = 1'b0;
  mrx_mii_t mii;
  mrx_mii_t pin;
  logic miiOe;
  logic carrierSense;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  int per;
  logic [3:0] q [$];
  mrx_row_t rows [4] = '{'{1'b1, 1'b1, 40}, '{1'b1, 1'b0, 40},
    '{1'b0, 1'b1, 400}, '{1'b0, 1'b0, 400}};
  // released pins float: a pattern that moves every cycle
  assign pin = miiOe ? mii : {7{core_clk}};

  // local reference; a quarter of it is the 25 MHz receive rate
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  mrx_receive i_mrx_receive (.core_clk(core_clk), .resetn(resetn),
    .lineClk(lineClk), .lineSym(lineSym), .linkUp(linkUp),
    .speed100(speed100), .rxTriReq(rxTriReq), .mii(mii), .miiOe(miiOe),
    .carrierSense(carrierSense));
  mrx_mac_model i_mrx_mac_model (.pin(pin), .rxTriReq(rxTriReq));

  // ********************************************************
  // tasks
  // ********************************************************
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, what,
        seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic line_sym(input mrx_sym_kind_t k, input logic [3:0] n);
    lineSym = '{k, n};
    #32 lineClk = 1'b1;
    #32 lineClk = 1'b0;
  endtask

  task automatic period(output int ns);
    time t0;
    @(posedge mii.clk);
    t0 = $time;
    @(posedge mii.clk);
    ns = int'($time - t0);
  endtask

  task automatic frame(input logic [3:0] n [$], input logic good);
    i_mrx_mac_model.nibbles.delete();
    i_mrx_mac_model.unstable = 0;
    i_mrx_mac_model.errs = 0;
    repeat (6) line_sym(SYM_IDLE, 4'h0);
    line_sym(SYM_SSD1, 4'h0);
    line_sym(SYM_SSD2, 4'h0);
    foreach (n[i]) line_sym(SYM_DATA, n[i]);
    if (good)
    begin
      line_sym(SYM_ESD1, 4'h0);
      line_sym(SYM_ESD2, 4'h0);
    end
    else
      line_sym(SYM_BAD, 4'h0);
    repeat (8) line_sym(SYM_IDLE, 4'h0);
    tick(100);
  endtask

  // ********************************************************
  // monitors and timeout
  // ********************************************************
  always @(posedge mii.dv)
  begin
    if (resetn)
      check(carrierSense, 1'b1, "valid before carrier");
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      end_sim();
    end
  end

  // ********************************************************
  // main sequence
  // ********************************************************
  initial
  begin
    // held past 8 cycles: line side needs its own edges in reset
    repeat (4) line_sym(SYM_IDLE, 4'h0);
    tick(8);
    check(miiOe, 1'b0, "enable in reset");
    check(mii, 7'h00, "pins in reset");
    resetn = 1'b1;
    tick(10);
    check(miiOe, 1'b1, "enable after reset");
    foreach (rows[i])
    begin
      speed100 = rows[i].spd;
      linkUp = rows[i].link;
      tick(100);
      period(per);
      period(per);
      check(per, rows[i].perNs, "clock period");
    end
    speed100 = 1'b1;
    linkUp = 1'b1;
    tick(50);
    frame('{4'h1, 4'h2, 4'h4, 4'h8}, 1'b1);
    check(i_mrx_mac_model.nibbles.size(), 4, "nibble count");
    foreach (i_mrx_mac_model.nibbles[i])
      check(i_mrx_mac_model.nibbles[i], 4'h1 << i, "nibble");
    check(mii.dv, 1'b0, "valid after end pair");
    check(i_mrx_mac_model.unstable, 0, "pins off edge");
    check(i_mrx_mac_model.errs, 0, "error in good frame");
    frame('{4'h5, 4'h6}, 1'b0);
    check(i_mrx_mac_model.nibbles.size(), 2, "abort count");
    check(mii.dv, 1'b0, "valid after abort");
    // lone first start then data: no stream may open
    i_mrx_mac_model.nibbles.delete();
    line_sym(SYM_SSD1, 4'h0);
    repeat (3) line_sym(SYM_DATA, 4'hA);
    repeat (6) line_sym(SYM_IDLE, 4'h0);
    tick(50);
    check(i_mrx_mac_model.nibbles.size(), 0, "stray valid");
    speed100 = 1'b0;
    tick(50);
    repeat (24) q.push_back(4'h3);
    repeat (2)
    begin
      frame(q, 1'b1);
      check(i_mrx_mac_model.nibbles.size() > 0, 1'b1, "slow valid");
      check(i_mrx_mac_model.nibbles[0], 4'h3, "slow nibble");
      check(mii.dv, 1'b0, "slow valid end");
      check(i_mrx_mac_model.errs, 0, "slow error");
    end
    rxTriReq = 1'b1;
    tick(10);
    check(miiOe, 1'b0, "released");
    rxTriReq = 1'b0;
    tick(10);
    check(miiOe, 1'b1, "driving again");
    end_sim();
  end
endmodule
`default_nettype wire
